/* File: inc/spdtx_pkg.sv */
package spdtx_pkg;
  // serial input formats
  typedef enum logic [1:0] {
    SPDTX_FMT_I2S,
    SPDTX_FMT_LJ,
    SPDTX_FMT_RJ
  } spdtx_fmt_t;

  // word width codes
  typedef enum logic [1:0] {
    SPDTX_W16,
    SPDTX_W18,
    SPDTX_W20,
    SPDTX_W24
  } spdtx_width_t;

  // oversampling ratio selection
  typedef enum logic {
    SPDTX_OSR_256,
    SPDTX_OSR_384
  } spdtx_osr_t;

  localparam int SPDTX_MAX_WORD = 24;
  localparam int SPDTX_FRAME_BCLKS = 64;
  localparam int SPDTX_HALF_BCLKS = 32;
  localparam logic [5:0] SPDTX_LJ_DELAY = 6'h00;
  localparam logic [5:0] SPDTX_I2S_DELAY = 6'h01;
  localparam logic [5:0] SPDTX_RJ_DELAY_16 = 6'h10;
  localparam logic [5:0] SPDTX_RJ_DELAY_18 = 6'h0e;
  localparam logic [5:0] SPDTX_RJ_DELAY_20 = 6'h0c;
  localparam logic [5:0] SPDTX_RJ_DELAY_24 = 6'h08;
  // biphase cells per frame: 64 slots x 2 cells
  localparam int SPDTX_CELLS_PER_FRAME = 128;
  localparam logic [8:0] SPDTX_DIV_256 = 9'h002;
  localparam logic [8:0] SPDTX_DIV_384 = 9'h003;
  localparam logic [4:0] SPDTX_RESET_CNT = 5'h00;

  // word length in bits for a width code
  function automatic logic [4:0] spdtx_word_len(input spdtx_width_t w);
    case (w)
      SPDTX_W16: spdtx_word_len = 5'h10;
      SPDTX_W18: spdtx_word_len = 5'h12;
      SPDTX_W20: spdtx_word_len = 5'h14;
      default: spdtx_word_len = 5'h18;
    endcase
  endfunction : spdtx_word_len

  // msb delay in bit clocks after a frame sync edge
  function automatic logic [5:0] spdtx_msb_delay(input spdtx_fmt_t f, input spdtx_width_t w);
    if (f == SPDTX_FMT_LJ) begin
      spdtx_msb_delay = SPDTX_LJ_DELAY;
    end else if (f == SPDTX_FMT_I2S) begin
      spdtx_msb_delay = SPDTX_I2S_DELAY;
    end else begin
      case (w)
        SPDTX_W16: spdtx_msb_delay = SPDTX_RJ_DELAY_16;
        SPDTX_W18: spdtx_msb_delay = SPDTX_RJ_DELAY_18;
        SPDTX_W20: spdtx_msb_delay = SPDTX_RJ_DELAY_20;
        default: spdtx_msb_delay = SPDTX_RJ_DELAY_24;
      endcase
    end
  endfunction : spdtx_msb_delay

  // left channel is frame sync high in lj/rj, low in i2s
  function automatic logic spdtx_is_left(input spdtx_fmt_t f, input logic fs);
    spdtx_is_left = (f == SPDTX_FMT_I2S) ? ~fs : fs;
  endfunction : spdtx_is_left
endpackage : spdtx_pkg

/* File: inc/spdtx_if.sv */
interface spdtx_if;
  // serial bit clock, frame sync, data; all change at source on a ref_clk edge
  logic bit_clock;
  logic frame_sync;
  logic serial_data;
  // oversampling clock, as a level sampled by ref_clk
  logic oversampling_clock;

  modport source (
    output bit_clock,
    output frame_sync,
    output serial_data,
    output oversampling_clock
  );

  modport sink (
    input bit_clock,
    input frame_sync,
    input serial_data,
    input oversampling_clock
  );
endinterface : spdtx_if

/* File: design/spdtx_source.sv */
// ----------------------------------------------------------------------------
// serial audio source: bit clock, frame sync, data, oversampling clock
// ----------------------------------------------------------------------------
module spdtx_source
  import spdtx_pkg::*;
#(
  parameter int BCLK_HALF = 4,
  parameter int OSC_HALF = 1
) (
  input wire logic ref_clk,
  input wire logic reset,
  spdtx_if.source link,
  input wire spdtx_pkg::spdtx_fmt_t fmt,
  input wire spdtx_pkg::spdtx_width_t width,
  input wire logic [23:0] left_word,
  input wire logic [23:0] right_word,
  output logic word_taken
);
  import spdtx_pkg::*;

  logic [7:0] half_q;
  logic [7:0] osc_q;
  logic bclk_q;
  logic osc_clk_q;
  logic [5:0] slot_q;
  logic fs_q;
  logic sd_q;
  logic [23:0] left_q;
  logic [23:0] right_q;
  logic taken_q;

  wire half_done = (half_q == 8'(BCLK_HALF - 1));
  wire fall_now = half_done && bclk_q;
  wire [5:0] next_slot = slot_q + 6'h01;
  wire [4:0] pos = next_slot[4:0];
  wire next_left_half = ~next_slot[5];
  wire [5:0] dly = spdtx_msb_delay(fmt, width);
  wire [4:0] wlen = spdtx_word_len(width);
  wire in_word = ({1'b0, pos} >= dly) && ({1'b0, pos} < dly + {1'b0, wlen});
  wire [4:0] bit_idx = 5'(wlen - 5'h01 - 5'(pos - dly[4:0]));
  wire [23:0] cur_word = next_left_half ? left_q : right_q;
  // i2s frame sync edge falls on the slot boundary, and the msb delay puts the msb one bit clock later
  wire fs_next = spdtx_is_left(fmt, 1'b1) ? next_left_half : ~next_left_half;

  // ----------------------------------------------------------------------------
  // clock generation
  // ----------------------------------------------------------------------------
  // oversampling clock driven
  // ratio per frame
  // the ratio is 64 x BCLK_HALF / OSC_HALF; the defaults give 256, and 384 needs BCLK_HALF 6
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      osc_q <= 8'h00;
      osc_clk_q <= 1'b0;
    end else if (osc_q == 8'(OSC_HALF - 1)) begin
      osc_q <= 8'h00;
      osc_clk_q <= ~osc_clk_q;
    end else begin
      osc_q <= osc_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------------------
  // frame generation
  // ----------------------------------------------------------------------------
  // change on falling edge, valid at rise
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      half_q <= 8'h00;
      bclk_q <= 1'b0;
      slot_q <= 6'h3f;
      fs_q <= 1'b0;
      sd_q <= 1'b0;
      left_q <= 24'h000000;
      right_q <= 24'h000000;
      taken_q <= 1'b0;
    end else begin
      taken_q <= 1'b0;
      if (half_done) begin
        half_q <= 8'h00;
        bclk_q <= ~bclk_q;
      end else begin
        half_q <= half_q + 8'h01;
      end
      if (fall_now) begin
        slot_q <= next_slot;
        fs_q <= fs_next;
        sd_q <= in_word ? cur_word[bit_idx] : 1'b0;
        if (next_slot == 6'h3f) begin
          left_q <= left_word;
          right_q <= right_word;
          taken_q <= 1'b1;
        end
      end
    end
  end

  assign link.bit_clock = bclk_q;
  assign link.frame_sync = fs_q;
  assign link.serial_data = sd_q;
  assign link.oversampling_clock = osc_clk_q;
  assign word_taken = taken_q;
endmodule : spdtx_source

/* File: design/spdtx_sink.sv */
// Function
// - lj: frame sync high means left
// - sample data, sync on bit clock rise
// - lj: msb right at sync edge
// - i2s: msb one bit clock later
// - divide oversampling clock to biphase rate
// - divider matches 384 or 256 ratio
// - i2s: frame sync low means left
// - rj: delay 16/14/12/8 per width
// - widths 16, 18, 20, 24 supported
module spdtx_sink
  import spdtx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  spdtx_if.sink link,
  input wire spdtx_pkg::spdtx_fmt_t fmt,
  input wire spdtx_pkg::spdtx_width_t width,
  input wire spdtx_pkg::spdtx_osr_t osr,
  output logic [23:0] left_sample,
  output logic [23:0] right_sample,
  output logic sample_valid,
  output logic biphase_tick
);
  import spdtx_pkg::*;

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  // delayed link levels, one ref_clk behind the pins
  logic bclk_q;
  logic osc_q;
  // frame sync level seen at the previous bit clock rise
  logic fs_prev_q;
  // bit clocks since the last sync edge; saturates so a lost sync cannot wrap
  logic [5:0] cnt_q;
  // bits taken of the current word, and the word so far, lsb last in
  logic [4:0] got_q;
  logic [23:0] shift_q;
  // channel of the word being shifted in; starts left, so a word before
  // the first sync edge is filed as left and never flagged on its own
  logic chan_left_q;
  // finished samples and their strobe
  logic [23:0] left_q;
  logic [23:0] right_q;
  logic valid_q;
  // biphase divider count and its output pulse
  logic [8:0] div_q;
  logic tick_q;

  // ----------------------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------------------
  // inputs are synchronous to ref_clk, so a plain delay register is enough;
  // a pin that could change off the ref_clk edge would need two flops here
  wire bclk_rise = link.bit_clock && !bclk_q;
  wire osc_rise = link.oversampling_clock && !osc_q;
  wire fs_edge = link.frame_sync != fs_prev_q;

  // reset values equal the idle levels of the source, so no false edge follows reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bclk_q <= 1'b0;
      osc_q <= 1'b0;
    end else begin
      bclk_q <= link.bit_clock;
      osc_q <= link.oversampling_clock;
    end
  end

  // ----------------------------------------------------------------------------
  // format decode
  // ----------------------------------------------------------------------------
  // msb delay per format
  wire [5:0] dly = spdtx_msb_delay(fmt, width);
  wire [4:0] wlen = spdtx_word_len(width);
  // bit count since the sync edge; the edge-carrying bit itself is count 0
  wire [5:0] pos = fs_edge ? 6'h00 : cnt_q;
  wire take_bit = (pos >= dly) && (got_q < wlen);
  wire last_bit = take_bit && (got_q == wlen - 5'h01);
  wire [23:0] shifted = {shift_q[22:0], link.serial_data};
  // only a zero-delay format takes a bit on the edge itself
  wire first_at_edge = (dly == 6'h00);
  wire edge_left = spdtx_is_left(fmt, link.frame_sync);

  // ----------------------------------------------------------------------------
  // word capture
  // ----------------------------------------------------------------------------
  // sample on rise
  // the count stops at its top, so bits long after the word stay ignored
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fs_prev_q <= 1'b0;
      cnt_q <= 6'h00;
    end else if (bclk_rise) begin
      fs_prev_q <= link.frame_sync;
      cnt_q <= (pos == 6'h3f) ? pos : pos + 6'h01;
    end
  end

  // channel from sync level
  // latched at the edge: the level is not looked at again until the next edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      chan_left_q <= 1'b1;
    end else if (bclk_rise && fs_edge) begin
      chan_left_q <= edge_left;
    end
  end

  // delay then width
  // a sync edge always restarts the word, so an early edge drops a short word
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      got_q <= SPDTX_RESET_CNT;
      shift_q <= 24'h000000;
    end else if (bclk_rise) begin
      if (fs_edge) begin
        got_q <= first_at_edge ? 5'h01 : SPDTX_RESET_CNT;
        shift_q <= first_at_edge ? {23'h000000, link.serial_data} : 24'h000000;
      end else if (take_bit) begin
        got_q <= got_q + 5'h01;
        shift_q <= shifted;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // sample hand-off
  // ----------------------------------------------------------------------------
  // short words are msb-aligned in the 24-bit output, low bits zero;
  // aligned is built from the shift input, so the last bit costs no extra cycle
  wire [4:0] pad = 5'(5'h18 - wlen);
  wire [23:0] aligned = shifted << pad;
  // at least 16 bits make a word, so none can finish on a sync edge
  wire done = bclk_rise && last_bit && !fs_edge;
  wire done_left = done && chan_left_q;
  wire done_right = done && !chan_left_q;

  // left word kept
  // the left word is held until its right partner completes the frame
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      left_q <= 24'h000000;
    end else if (done_left) begin
      left_q <= aligned;
    end
  end

  // frame complete after right word; the strobe stands one cycle
  // in i2s the first half frame after reset has no edge, and its word is flagged as left with the first right word
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      right_q <= 24'h000000;
      valid_q <= 1'b0;
    end else begin
      valid_q <= done_right;
      if (done_right) begin
        right_q <= aligned;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // biphase clock divider
  // ----------------------------------------------------------------------------
  // ratio picks divider
  // both ratios give 128 cells per frame; a ratio that does not match the
  // oversampling clock gives a wrong cell rate, and nothing here can tell
  wire [8:0] div_max = (osr == SPDTX_OSR_384) ? SPDTX_DIV_384 : SPDTX_DIV_256;
  // compared with >= so a ratio change mid-run cannot strand the count above the top
  wire div_wrap = (div_q >= div_max - 9'h001);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_q <= 9'h000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (osc_rise) begin
        if (div_wrap) begin
          div_q <= 9'h000;
          tick_q <= 1'b1;
        end else begin
          div_q <= div_q + 9'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  // all four come straight from flip-flops
  assign left_sample = left_q;
  assign right_sample = right_q;
  assign sample_valid = valid_q;
  assign biphase_tick = tick_q;
endmodule : spdtx_sink

/* File: tb/spdtx_assertions.sv */
// ----------------------------------------------------------------------------
// link and sink output checks
// ----------------------------------------------------------------------------
module spdtx_assertions
  import spdtx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic bit_clock,
  input wire logic frame_sync,
  input wire logic serial_data,
  input wire logic oversampling_clock,
  input wire spdtx_pkg::spdtx_fmt_t fmt,
  input wire spdtx_pkg::spdtx_osr_t osr,
  input wire logic sample_valid,
  input wire logic biphase_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] rises_q;
  logic seen_q;
  logic fs_q;
  logic bclk_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // bit clock rises since the last frame sync edge; first edge is skipped
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rises_q <= 7'h00;
      seen_q <= 1'b0;
      fs_q <= 1'b0;
      bclk_q <= 1'b0;
    end else begin
      fs_q <= frame_sync;
      bclk_q <= bit_clock;
      if (frame_sync != fs_q) begin
        rises_q <= 7'h00;
        seen_q <= 1'b1;
      end else if (bit_clock && !bclk_q) begin
        rises_q <= rises_q + 7'h01;
      end
    end
  end

  chk_data_at_fall:
    assert property ($changed(serial_data) |-> $fell(bit_clock))
    else $error("serial data moved off a bit clock fall");
  chk_sync_at_fall:
    assert property ($changed(frame_sync) |-> $fell(bit_clock))
    else $error("frame sync moved off a bit clock fall");
  chk_bclk_high_len:
    assert property ($rose(bit_clock) |=> bit_clock [*3] ##1 !bit_clock)
    else $error("bit clock high phase is not four cycles");
  chk_half_frame_len:
    assert property (seen_q && (frame_sync != fs_q) |-> rises_q == 7'h20)
    else $error("half frame is not 32 bit clocks");
  chk_tick_osc_rise:
    assert property (biphase_tick |-> $past(oversampling_clock) && !$past(oversampling_clock, 2))
    else $error("biphase tick not one cycle after an oversampling rise");
  chk_div_by_two:
    assert property (biphase_tick && osr == SPDTX_OSR_256 |=> !biphase_tick [*3] ##1 biphase_tick)
    else $error("biphase tick spacing wrong for ratio 256");
  chk_div_by_three:
    assert property (biphase_tick && osr == SPDTX_OSR_384 |=> !biphase_tick [*5] ##1 biphase_tick)
    else $error("biphase tick spacing wrong for ratio 384");
  chk_valid_right_side:
    assert property (sample_valid |-> frame_sync == (fmt == SPDTX_FMT_I2S))
    else $error("sample valid outside the right channel half");
endmodule : spdtx_assertions

/* File: tb/spdtx_test.sv */
// ----------------------------------------------------------------------------
// source and sink face to face
// ----------------------------------------------------------------------------
module spdtx_test;
  timeunit 1ns;
  timeprecision 1ps;
  import spdtx_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  spdtx_fmt_t fmt = SPDTX_FMT_I2S;
  spdtx_width_t width = SPDTX_W16;
  spdtx_osr_t osr = SPDTX_OSR_256;
  logic [23:0] left_word = 24'ha5c3f1;
  logic [23:0] right_word = 24'h3c5a0e;
  logic [23:0] left_sample;
  logic [23:0] right_sample;
  logic sample_valid;
  logic biphase_tick;
  logic word_taken;
  localparam int BCLK_HALF = 4;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;

  spdtx_if link ();
  spdtx_source #(.BCLK_HALF(BCLK_HALF)) u_spdtx_source (.ref_clk(ref_clk), .reset(reset),
    .link(link.source), .fmt(fmt), .width(width), .left_word(left_word),
    .right_word(right_word), .word_taken(word_taken));
  spdtx_sink u_spdtx_sink (.ref_clk(ref_clk), .reset(reset), .link(link.sink), .fmt(fmt),
    .width(width), .osr(osr), .left_sample(left_sample), .right_sample(right_sample),
    .sample_valid(sample_valid), .biphase_tick(biphase_tick));
  spdtx_assertions u_spdtx_assertions (.ref_clk(ref_clk), .reset(reset),
    .bit_clock(link.bit_clock), .frame_sync(link.frame_sync), .serial_data(link.serial_data),
    .oversampling_clock(link.oversampling_clock), .fmt(fmt), .osr(osr),
    .sample_valid(sample_valid), .biphase_tick(biphase_tick));

  always #2 ref_clk = ~ref_clk;

  // hang guard: whole run needs about 14000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic do_reset(input spdtx_fmt_t f, input spdtx_width_t w, input spdtx_osr_t o);
    @(posedge ref_clk);
    reset <= 1'b1;
    fmt <= f;
    width <= w;
    osr <= o;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
  endtask : do_reset

  // bounded wait for one valid pulse, a frame is 512 cycles
  task automatic wait_valid;
    for (int i = 0; i < 1200; i++) begin
      @(posedge ref_clk);
      #1;
      if (sample_valid === 1'b1) return;
    end
    check("sample_valid", 24'h0, 24'h1);
  endtask : wait_valid

  // second frame checked: the source sends zero words in the first, as it loads words only at frame end
  task automatic frame_check(input int wl);
    wait_valid();
    wait_valid();
    check("left_sample", left_sample, left_word << (24 - wl));
    check("right_sample", right_sample, right_word << (24 - wl));
  endtask : frame_check

  // every format with every width
  task automatic t_formats;
    for (int fi = 0; fi < 3; fi++) begin
      for (int wi = 0; wi < 4; wi++) begin
        do_reset(spdtx_fmt_t'(fi), spdtx_width_t'(wi), SPDTX_OSR_256);
        frame_check((wi == 3) ? 24 : 16 + 2 * wi);
      end
    end
  endtask : t_formats

  // divider ratio: ticks in 120 cycles after the first one
  task automatic t_divider;
    int n;
    for (int o = 0; o < 2; o++) begin
      do_reset(SPDTX_FMT_LJ, SPDTX_W24, spdtx_osr_t'(o));
      // the source clock is fixed at 256 per frame, so at 384 only the spacing is judged
      for (int i = 0; i < 20 && biphase_tick !== 1'b1; i++) begin
        @(posedge ref_clk);
        #1;
      end
      n = 0;
      repeat (120) begin
        @(posedge ref_clk);
        #1;
        if (biphase_tick === 1'b1) n++;
      end
      check("biphase_tick count", 24'(n), (o == 1) ? 24'd20 : 24'd30);
    end
  endtask : t_divider

  // one frame lies between two word_taken pulses: 64 bit clocks, 128 cells at ratio 256
  task automatic t_frame_rate;
    int cyc;
    int ticks;
    do_reset(SPDTX_FMT_RJ, SPDTX_W20, SPDTX_OSR_256);
    cyc = 0;
    ticks = 0;
    for (int i = 0; i < 1200 && word_taken !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    check("word_taken", {23'h000000, word_taken}, 24'h000001);
    for (int i = 0; i < 1200 && (cyc == 0 || word_taken !== 1'b1); i++) begin
      @(posedge ref_clk);
      #1;
      cyc++;
      if (biphase_tick === 1'b1) ticks++;
    end
    check("frame cycles", 24'(cyc), 24'(2 * BCLK_HALF * SPDTX_FRAME_BCLKS));
    check("ticks per frame", 24'(ticks), 24'(SPDTX_CELLS_PER_FRAME));
  endtask : t_frame_rate

  // reset in mid frame, new words and format must take over cleanly
  task automatic t_reset_mid;
    do_reset(SPDTX_FMT_I2S, SPDTX_W20, SPDTX_OSR_384);
    repeat (300) @(posedge ref_clk);
    left_word <= 24'h0f1e2d;
    right_word <= 24'h30c3a5;
    do_reset(SPDTX_FMT_LJ, SPDTX_W18, SPDTX_OSR_256);
    frame_check(18);
  endtask : t_reset_mid

  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    t_formats();
    t_divider();
    t_frame_rate();
    t_reset_mid();
    end_of_test();
  end
endmodule : spdtx_test
